/* File: rtl/rtcai_top.sv */
// Alarm match, alarm flag and open-drain alarm interrupt of a real-time clock
//
// Overview of operation
// - A match on all compared items sets the alarm flag.
// - With interrupt enable set, a match pulls the alarm pin low.
// - Bit 7 of an alarm register drops that item from comparison.
// - With all four items excluded, an alarm occurs every minute.
// - Weekday alarm is a bitmap; any set weekday that matches satisfies it.
// - The alarm flag stays one until software writes zero to it.
// - Writing zero clears the flag and releases the alarm pin.
// - Writing one to the alarm flag changes nothing.
// - Interrupt enable at zero keeps or returns the pin to high impedance.
// - A match sets the flag even with the interrupt disabled.
// - The hour alarm compares as a 24-hour BCD value.
// - Alarm registers may be plain storage; comparison continues regardless.
// - Setting alarm equal to present time does not trigger at once.
`timescale 1ns/1ps
`include "rtcai_map.svh"

module rtcai_top (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Register access port
    input  wire rtcai_pkg::rtcai_regbus_t rbus,
    output logic [7:0]                  reg_rdata,
    output logic                        reg_rvalid,
    // Running time from the time counters
    input  wire rtcai_pkg::rtcai_time_t cur_time,
    input  wire logic                   time_update,
    // Writes forwarded to the time counters
    output logic                        time_wr,
    output logic [3:0]                  time_wr_addr,
    output logic [7:0]                  time_wr_data,
    // Fixed-cycle timer side of the shared control register
    input  wire logic                   timer_event,
    output logic                        timer_flag,
    output logic                        timer_irq_enable,
    output logic                        timer_repeat_select,
    // Alarm status
    output logic                        alarm_flag,
    output logic                        alarm_irq_enable,
    // Open-drain alarm interrupt pin
    input  wire logic                   alarm_irq_n_in,
    output logic                        alarm_irq_n_out,
    output logic                        alarm_irq_n_oe
);

    // Alarm setting registers
    rtcai_pkg::rtcai_time_t alarm_set;

    // Address decode
    wire logic sel_cur;
    wire logic sel_alm_min;
    wire logic sel_alm_hour;
    wire logic sel_alm_week;
    wire logic sel_alm_date;
    wire logic sel_ctrl;
    wire logic wr_ctrl;

    assign sel_cur      = (rbus.addr == `RTCAI_ADDR_CUR_MIN)
                        | (rbus.addr == `RTCAI_ADDR_CUR_HOUR)
                        | (rbus.addr == `RTCAI_ADDR_CUR_WEEK)
                        | (rbus.addr == `RTCAI_ADDR_CUR_DATE);
    assign sel_alm_min  = rbus.addr == `RTCAI_ADDR_ALM_MIN;
    assign sel_alm_hour = rbus.addr == `RTCAI_ADDR_ALM_HOUR;
    assign sel_alm_week = rbus.addr == `RTCAI_ADDR_ALM_WEEK;
    assign sel_alm_date = rbus.addr == `RTCAI_ADDR_ALM_DATE;
    assign sel_ctrl     = rbus.addr == `RTCAI_ADDR_CTRL;
    assign wr_ctrl      = rbus.wr & sel_ctrl;

    // Comparator on the running time
    wire logic alarm_match;

    rtcai_match u_match (
        .cur_time  (cur_time),
        .alarm_set (alarm_set),
        .match     (alarm_match)
    );

    // Only the minute update can raise an alarm, so a fresh setting equal
    // to the present time waits for the counters to come round again
    wire logic alarm_event;

    assign alarm_event = time_update & alarm_match;

    // Flag clears: a zero in the flag position of a control write
    wire logic af_clr;
    wire logic tf_clr;

    assign af_clr = wr_ctrl & ~rbus.wdata[`RTCAI_BIT_AF];
    assign tf_clr = wr_ctrl & ~rbus.wdata[`RTCAI_BIT_TF];

    // Alarm flag, raised regardless of interrupt enable
    wire logic next_alarm_flag;

    rtcai_flag u_alarm_flag (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .set_evt   (alarm_event),
        .clr_req   (af_clr),
        .flag      (alarm_flag),
        .next_flag (next_alarm_flag)
    );

    // Timer flag, kept here because it shares the control register
    rtcai_flag u_timer_flag (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .set_evt   (timer_event),
        .clr_req   (tf_clr),
        .flag      (timer_flag),
        .next_flag ()
    );

    // Next value of the alarm interrupt enable
    wire logic next_aie;

    assign next_aie = wr_ctrl ? rbus.wdata[`RTCAI_BIT_AIE] : alarm_irq_enable;

    // Pin drive follows flag and enable; losing either releases it at once
    wire logic next_irq_oe;

    assign next_irq_oe = next_alarm_flag & next_aie;

    // Control register bits written by software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_irq_enable    <= `RTCAI_RST_BIT;
            timer_irq_enable    <= `RTCAI_RST_BIT;
            timer_repeat_select <= `RTCAI_RST_BIT;
        end else if (wr_ctrl) begin
            alarm_irq_enable    <= rbus.wdata[`RTCAI_BIT_AIE];
            timer_irq_enable    <= rbus.wdata[`RTCAI_BIT_TIE];
            timer_repeat_select <= rbus.wdata[`RTCAI_BIT_REPEAT];
        end
    end

    // Open-drain alarm pin: only ever driven low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_irq_n_out <= 1'h0;
            alarm_irq_n_oe  <= 1'h0;
        end else begin
            alarm_irq_n_out <= 1'h0;
            alarm_irq_n_oe  <= next_irq_oe;
        end
    end

    // Alarm registers, kept compared even when used as storage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_set <= {4{`RTCAI_RST_ALARM}};
        end else if (rbus.wr) begin
            if (sel_alm_min) begin
                alarm_set.minutes <= rbus.wdata;
            end
            if (sel_alm_hour) begin
                alarm_set.hours <= rbus.wdata;
            end
            if (sel_alm_week) begin
                alarm_set.weekday <= rbus.wdata;
            end
            if (sel_alm_date) begin
                alarm_set.date <= rbus.wdata;
            end
        end
    end

    // Current-time writes are passed on to the counters
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            time_wr      <= 1'h0;
            time_wr_addr <= 4'h0;
            time_wr_data <= 8'h00;
        end else begin
            time_wr      <= rbus.wr & sel_cur;
            time_wr_addr <= rbus.addr;
            time_wr_data <= rbus.wdata;
        end
    end

    // Control register image, unused high bits read zero
    wire logic [7:0] ctrl_image;

    assign ctrl_image = {3'h0, timer_repeat_select, alarm_flag, timer_flag,
                         alarm_irq_enable, timer_irq_enable};

    // Read selection
    wire logic [7:0] rd_mux;

    assign rd_mux = (rbus.addr == `RTCAI_ADDR_CUR_MIN)  ? cur_time.minutes  :
                    (rbus.addr == `RTCAI_ADDR_CUR_HOUR) ? cur_time.hours    :
                    (rbus.addr == `RTCAI_ADDR_CUR_WEEK) ? cur_time.weekday  :
                    (rbus.addr == `RTCAI_ADDR_CUR_DATE) ? cur_time.date     :
                    sel_alm_min                         ? alarm_set.minutes :
                    sel_alm_hour                        ? alarm_set.hours   :
                    sel_alm_week                        ? alarm_set.weekday :
                    sel_alm_date                        ? alarm_set.date    :
                    sel_ctrl                            ? ctrl_image        :
                                                          `RTCAI_RD_UNMAPPED;

    // Read data register, valid one cycle after the request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'h0;
        end else begin
            reg_rvalid <= rbus.rd;
            if (rbus.rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    // Helper: all four items excluded
    wire logic all_excluded;

    assign all_excluded = alarm_set.minutes[`RTCAI_BIT_EXCLUDE]
                        & alarm_set.hours[`RTCAI_BIT_EXCLUDE]
                        & alarm_set.weekday[`RTCAI_BIT_EXCLUDE]
                        & alarm_set.date[`RTCAI_BIT_EXCLUDE];

    // Flag rises on a matching minute update
    af_set_match_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        time_update && alarm_match |=> alarm_flag)
        else $error("alarm flag not set after match");

    // Flag holds until a zero is written
    af_sticky_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        alarm_flag && !af_clr |=> alarm_flag)
        else $error("alarm flag dropped without clear");

    // Clear without a fresh event empties the flag and frees the pin
    af_clear_pin_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        af_clr && !alarm_event |=> !alarm_flag && !alarm_irq_n_oe)
        else $error("clear did not release flag or pin");

    // A one in the flag position leaves a clear flag clear
    af_write_one_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_ctrl && rbus.wdata[`RTCAI_BIT_AF] && !alarm_flag && !alarm_event
        |=> !alarm_flag)
        else $error("writing one changed the alarm flag");

    // Pin is driven exactly while flag and enable are both set
    irq_drive_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        alarm_irq_n_oe == (alarm_flag && alarm_irq_enable))
        else $error("alarm pin drive disagrees with flag and enable");

    // Disabling the interrupt frees the pin on the next edge
    irq_disable_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_ctrl && !rbus.wdata[`RTCAI_BIT_AIE] |=> !alarm_irq_n_oe && !alarm_irq_n_out)
        else $error("alarm pin driven with interrupt disabled");

    // Polling mode: flag rises, pin stays released
    poll_mode_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        alarm_event && !next_aie |=> alarm_flag && !alarm_irq_n_oe)
        else $error("polling alarm misbehaved");

    // No minute update, no new alarm
    no_update_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !alarm_flag && !time_update |=> !alarm_flag)
        else $error("alarm flag rose without minute update");

    // Everything excluded fires on every minute update
    every_minute_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        time_update && all_excluded |=> alarm_flag)
        else $error("fully excluded alarm missed a minute");

    // Weekday bitmap hit with other items excluded
    weekday_hit_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        time_update && alarm_set.minutes[7] && alarm_set.hours[7] && alarm_set.date[7]
        && !alarm_set.weekday[7] && |(alarm_set.weekday[6:0] & cur_time.weekday[6:0])
        |=> alarm_flag)
        else $error("weekday bitmap hit not recognised");

    // Included hour mismatch blocks the alarm
    hour_block_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        time_update && !alarm_flag && !alarm_set.hours[7]
        && alarm_set.hours[5:0] != cur_time.hours[5:0] |=> !alarm_flag)
        else $error("hour mismatch raised alarm");

    // Control read shows zero high bits one cycle later
    ctrl_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rbus.rd && sel_ctrl |=> reg_rvalid && reg_rdata[7:5] == 3'h0)
        else $error("control read wrong");

    // Set beats a clear written in the same cycle
    af_set_wins_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        alarm_event && af_clr |=> alarm_flag)
        else $error("clear beat a simultaneous alarm event");

    // Pin only ever pulls low
    irq_low_only_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        alarm_irq_n_oe |-> !alarm_irq_n_out)
        else $error("alarm pin driven high");

    // Driven pin stays low until a flag clear or an enable clear
    irq_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        alarm_irq_n_oe && !af_clr && !(wr_ctrl && !rbus.wdata[`RTCAI_BIT_AIE])
        |=> alarm_irq_n_oe)
        else $error("alarm pin released on its own");

    // Raising the enable while the flag is set drives the pin
    irq_reenable_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        alarm_flag && !af_clr && wr_ctrl && rbus.wdata[`RTCAI_BIT_AIE] |=> alarm_irq_n_oe)
        else $error("enable with flag set left pin released");

    // Interrupt disabled: no match can pull the pin
    irq_masked_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !alarm_irq_n_oe && !next_aie |=> !alarm_irq_n_oe)
        else $error("pin pulled with interrupt disabled");

    // Weekday alarm register writes are stored as written
    alarm_store_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rbus.wr && sel_alm_week |=> alarm_set.weekday == $past(rbus.wdata))
        else $error("alarm register lost written data");

    // Included minute mismatch blocks the alarm
    min_block_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        time_update && !alarm_flag && !alarm_set.minutes[`RTCAI_BIT_EXCLUDE]
        && alarm_set.minutes[6:0] != cur_time.minutes[6:0] |=> !alarm_flag)
        else $error("minute mismatch raised alarm");

endmodule

/* File: inc/rtcai_map.svh */
// Register offsets, field positions and reset values of the alarm interrupt block
`ifndef RTCAI_MAP_SVH
`define RTCAI_MAP_SVH

`define RTCAI_ADDR_CUR_MIN   4'h1
`define RTCAI_ADDR_CUR_HOUR  4'h2
`define RTCAI_ADDR_CUR_WEEK  4'h3
`define RTCAI_ADDR_CUR_DATE  4'h4
`define RTCAI_ADDR_ALM_MIN   4'h7
`define RTCAI_ADDR_ALM_HOUR  4'h8
`define RTCAI_ADDR_ALM_WEEK  4'h9
`define RTCAI_ADDR_ALM_DATE  4'ha
`define RTCAI_ADDR_CTRL      4'he

`define RTCAI_BIT_EXCLUDE    7
`define RTCAI_BIT_REPEAT     4
`define RTCAI_BIT_AF         3
`define RTCAI_BIT_TF         2
`define RTCAI_BIT_AIE        1
`define RTCAI_BIT_TIE        0

`define RTCAI_RST_ALARM      8'h00
`define RTCAI_RST_BIT        1'h0
`define RTCAI_RD_UNMAPPED    8'h00

`endif

/* File: inc/rtcai_pkg.sv */
// Types shared by the alarm interrupt block
package rtcai_pkg;

    // One set of minute, hour, weekday and date bytes
    typedef struct packed {
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] weekday;
        logic [7:0] date;
    } rtcai_time_t;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rtcai_regbus_t;

endpackage

/* File: rtl/rtcai_match.sv */
// Alarm comparator: current time against alarm settings with per-item exclusion
`timescale 1ns/1ps
`include "rtcai_map.svh"

module rtcai_match (
    // Operands
    input  wire rtcai_pkg::rtcai_time_t cur_time,
    input  wire rtcai_pkg::rtcai_time_t alarm_set,
    // Result
    output wire logic                   match
);

    // Item equality, bit 7 of current registers ignored
    wire logic min_eq;
    wire logic hour_eq;
    wire logic week_hit;
    wire logic date_eq;

    assign min_eq   = alarm_set.minutes[6:0] == cur_time.minutes[6:0];
    assign hour_eq  = alarm_set.hours[5:0] == cur_time.hours[5:0];
    assign week_hit = |(alarm_set.weekday[6:0] & cur_time.weekday[6:0]);
    assign date_eq  = alarm_set.date[5:0] == cur_time.date[5:0];

    // Excluded items always pass, so all excluded matches every minute
    assign match = (alarm_set.minutes[`RTCAI_BIT_EXCLUDE] | min_eq)
                 & (alarm_set.hours[`RTCAI_BIT_EXCLUDE]   | hour_eq)
                 & (alarm_set.weekday[`RTCAI_BIT_EXCLUDE] | week_hit)
                 & (alarm_set.date[`RTCAI_BIT_EXCLUDE]    | date_eq);

endmodule

/* File: rtl/rtcai_flag.sv */
// Sticky event flag: set by hardware, cleared by writing zero, set wins
`timescale 1ns/1ps
`include "rtcai_map.svh"

module rtcai_flag (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Control
    input  wire logic set_evt,
    input  wire logic clr_req,
    // State
    output logic      flag,
    output wire logic next_flag
);

    // Set beats a clear in the same cycle
    assign next_flag = set_evt | (flag & ~clr_req);

    // Flag storage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag <= `RTCAI_RST_BIT;
        end else begin
            flag <= next_flag;
        end
    end

endmodule

/* File: tb/rtcai_host.sv */
// Host side of the open-drain alarm interrupt line with its pull-up
`timescale 1ns/1ps
module rtcai_host (
    // Pin driver of the device
    input  wire logic alarm_irq_n_out,
    input  wire logic alarm_irq_n_oe,
    // Resolved line level
    output wire logic alarm_irq_n_in,
    output wire logic irq_pin
);
    // Pull-up holds the line high whenever the device lets go of it
    assign irq_pin        = alarm_irq_n_oe ? alarm_irq_n_out : 1'b1;
    assign alarm_irq_n_in = irq_pin;
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the alarm match, alarm flag and alarm interrupt pin
`timescale 1ns/1ps
`include "rtcai_map.svh"
module tb;
    // Design connections
    logic                     clk_sys;
    logic                     rst_n;
    logic                     time_update;
    logic                     timer_event;
    rtcai_pkg::rtcai_regbus_t rbus;
    rtcai_pkg::rtcai_time_t   cur_time;
    logic [7:0]               reg_rdata;
    logic [7:0]               time_wr_data;
    logic [3:0]               time_wr_addr;
    logic                     reg_rvalid;
    logic                     time_wr;
    logic                     timer_flag;
    logic                     timer_irq_enable;
    logic                     timer_repeat_select;
    logic                     alarm_flag;
    logic                     alarm_irq_enable;
    logic                     alarm_irq_n_out;
    logic                     alarm_irq_n_oe;
    wire logic                alarm_irq_n_in;
    wire logic                irq_pin;
    int                       mismatches;
    int                       n_compared;
    logic [7:0]               rv;

    // Rows: alarm settings, running time, expected alarm flag (bit i is row i)
    localparam logic [31:0] alm_tab [7] = '{32'h4523_8001, 32'h4523_8001, 32'h8080_8080,
        32'h8007_3e80, 32'h8007_3e80, 32'h3080_8080, 32'h3080_8085};
    localparam logic [31:0] cur_tab [7] = '{32'h4523_0401, 32'h4522_0401, 32'h1213_0215,
        32'h0007_0415, 32'h0007_0115, 32'h3100_0101, 32'h3000_0101};
    localparam logic [6:0]  exp_tab     = 7'b1001101;

    rtcai_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .rbus(rbus), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .cur_time(cur_time), .time_update(time_update),
        .time_wr(time_wr), .time_wr_addr(time_wr_addr), .time_wr_data(time_wr_data),
        .timer_event(timer_event), .timer_flag(timer_flag),
        .timer_irq_enable(timer_irq_enable), .timer_repeat_select(timer_repeat_select),
        .alarm_flag(alarm_flag), .alarm_irq_enable(alarm_irq_enable),
        .alarm_irq_n_in(alarm_irq_n_in), .alarm_irq_n_out(alarm_irq_n_out),
        .alarm_irq_n_oe(alarm_irq_n_oe));

    rtcai_host host (.alarm_irq_n_out(alarm_irq_n_out), .alarm_irq_n_oe(alarm_irq_n_oe),
        .alarm_irq_n_in(alarm_irq_n_in), .irq_pin(irq_pin));

    // Clock of 25 ns
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Verdict and end of run
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Register write, taken at the next edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 rbus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        #1 rbus.wr = 1'b0;
    endtask

    // Register read with a bounded wait for the answer
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1 rbus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        #1 rbus.rd = 1'b0;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (reg_rvalid !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: read answer missing", $time);
            final_report();
        end
        d = reg_rdata;
    endtask

    // Minute update from the time counters
    task automatic tick(input logic [31:0] t);
        @(posedge clk_sys);
        #1 cur_time = t;
        time_update = 1'b1;
        @(posedge clk_sys);
        #1 time_update = 1'b0;
    endtask

    // Alarm status: control image, pin drive and line level
    task automatic st(input logic [7:0] c, input logic oe, input string msg);
        rd(`RTCAI_ADDR_CTRL, rv);
        chk(rv, c, msg);
        chk({7'h00, alarm_irq_n_oe}, {7'h00, oe}, msg);
        chk({7'h00, irq_pin}, {7'h00, ~oe}, msg);
        chk({6'h00, alarm_flag, alarm_irq_enable}, {6'h00, c[`RTCAI_BIT_AF], c[`RTCAI_BIT_AIE]}, msg);
        chk({7'h00, alarm_irq_n_out}, 8'h00, msg);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        final_report();
    end

    initial begin
        rbus = '0;
        cur_time = '0;
        time_update = 1'b0;
        timer_event = 1'b0;
        rst_n = 1'b0;
        mismatches = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        for (int a = 7; a <= 10; a++) begin
            rd(4'(a), rv);
            chk(rv, `RTCAI_RST_ALARM, "alarm reset value");
        end
        st(8'h00, 1'b0, "control reset value");
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            wr(`RTCAI_ADDR_CTRL, 8'h00);
            for (int j = 0; j < 4; j++) wr(4'(7 + j), alm_tab[i][31 - 8 * j -: 8]);
            for (int j = 0; j < 4; j++) begin
                rd(4'(7 + j), rv);
                chk(rv, alm_tab[i][31 - 8 * j -: 8], "alarm storage");
            end
            tick(cur_tab[i]);
            st({4'h0, exp_tab[i], 3'h0}, 1'b0, "alarm match row");
        end
        $display("test match table done");
        // Alarm equal to present time, no minute update yet
        @(posedge clk_sys);
        #1 cur_time = 32'h2010_0101;
        wr(`RTCAI_ADDR_CTRL, 8'h02);
        for (int j = 0; j < 4; j++) wr(4'(7 + j), cur_time[31 - 8 * j -: 8]);
        repeat (3) @(posedge clk_sys);
        st(8'h02, 1'b0, "no alarm without update");
        tick(32'h2010_0101);
        st(8'h0a, 1'b1, "alarm drives pin");
        wr(`RTCAI_ADDR_CTRL, 8'h0a);
        repeat (5) @(posedge clk_sys);
        st(8'h0a, 1'b1, "flag kept, write one ignored");
        wr(`RTCAI_ADDR_CTRL, 8'h08);
        st(8'h08, 1'b0, "enable off releases pin");
        wr(`RTCAI_ADDR_CTRL, 8'h0a);
        st(8'h0a, 1'b1, "enable on while flag set");
        wr(`RTCAI_ADDR_CTRL, 8'h02);
        st(8'h02, 1'b0, "flag clear releases pin");
        wr(`RTCAI_ADDR_CTRL, 8'h00);
        tick(32'h2010_0101);
        st(8'h08, 1'b0, "polling without pin");
        $display("test alarm pin done");
        // Unmapped place, reserved bits and shared control bits
        wr(4'h5, 8'hff);
        rd(4'h5, rv);
        chk(rv, `RTCAI_RD_UNMAPPED, "unmapped read");
        wr(`RTCAI_ADDR_CTRL, 8'hff);
        st(8'h1b, 1'b1, "reserved bits and flags");
        chk({6'h00, timer_irq_enable, timer_repeat_select}, 8'h03, "timer bits");
        wr(`RTCAI_ADDR_CUR_MIN, 8'h59);
        chk({3'h0, time_wr, time_wr_addr}, 8'h11, "time write forward");
        chk(time_wr_data, 8'h59, "time write data");
        @(posedge clk_sys);
        #1 timer_event = 1'b1;
        @(posedge clk_sys);
        #1 timer_event = 1'b0;
        chk({7'h00, timer_flag}, 8'h01, "timer flag set");
        $display("test control done");
        // Flag clear and alarm event in one cycle: the event wins
        @(posedge clk_sys);
        #1 rbus = '{wr: 1'b1, rd: 1'b0, addr: `RTCAI_ADDR_CTRL, wdata: 8'h02};
        time_update = 1'b1;
        @(posedge clk_sys);
        #1 rbus.wr = 1'b0;
        time_update = 1'b0;
        st(8'h0a, 1'b1, "set wins over clear");
        chk({7'h00, timer_flag}, 8'h00, "timer flag cleared");
        // Reset in mid-run with the pin driven
        @(posedge clk_sys);
        #1 rst_n = 1'b0;
        @(posedge clk_sys);
        #1 rst_n = 1'b1;
        chk({5'h00, alarm_flag, alarm_irq_n_oe, timer_irq_enable}, 8'h00, "reset in mid-run");
        st(8'h00, 1'b0, "control after mid-run reset");
        rd(`RTCAI_ADDR_ALM_MIN, rv);
        chk(rv, `RTCAI_RST_ALARM, "alarm after mid-run reset");
        $display("test awkward cases done");
        final_report();
    end
endmodule
